// file: core/iidr_pkg.sv
`default_nettype none
package iidr_pkg;
    localparam int CLK_NS = 20;
    localparam int NCH = 8;
    localparam int NS_PER_MS = 1000000;
    // register addresses
    localparam logic [7:0] ADDR_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_KIND_LO = 8'h01;
    localparam logic [7:0] ADDR_KIND_HI = 8'h02;
    localparam logic [7:0] ADDR_DLY_LO = 8'h03;
    localparam logic [7:0] ADDR_DLY_HI = 8'h04;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // default code mapping of the two-bit fields
    localparam logic [1:0] MODE_DEGLITCH = 2'h0;
    localparam logic [1:0] MODE_LOWPASS = 2'h1;
    localparam logic [1:0] MODE_BLANKING = 2'h2;
    localparam logic [1:0] DLY_CODE_NONE = 2'h0;
    localparam logic [1:0] DLY_CODE_A = 2'h1;
    localparam logic [1:0] DLY_CODE_B = 2'h2;
    localparam logic [1:0] DLY_CODE_C = 2'h3;
    // timing
    localparam int FIXED_LP_NS = 4000;
    localparam int FIXED_LP_CYC = (FIXED_LP_NS + CLK_NS - 1) / CLK_NS;
    localparam int START_NS = 40000;
    localparam int START_CYC = (START_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLY_A_MS = 10;
    localparam int DLY_B_MS = 30;
    localparam int DLY_C_MS = 100;
    localparam int DLY_A_CYC = DLY_A_MS * (NS_PER_MS / CLK_NS);
    localparam int DLY_B_CYC = DLY_B_MS * (NS_PER_MS / CLK_NS);
    localparam int DLY_C_CYC = DLY_C_MS * (NS_PER_MS / CLK_NS);
    localparam int DLY_W = 23;
    localparam int LP_W = 8;
    localparam int START_W = 12;
    // serial control byte; id bits arrive least significant first
    typedef struct packed {
        logic bcast;
        logic rnw;
        logic [1:0] rsvd;
        logic [3:0] cid_rev;
    } iidr_ctl_type;
    // channel configuration carried between domains
    typedef struct packed {
        logic [7:0] dly_hi;
        logic [7:0] dly_lo;
        logic [7:0] kind_hi;
        logic [7:0] kind_lo;
    } iidr_cfg_type;
    typedef enum logic [1:0] {ST_LOCKED, ST_STARTING, ST_ZERO, ST_TRACK} iidr_pwr_type;
endpackage
`default_nettype wire

// file: core/iidr_top.sv
`timescale 1ns/100ps
`default_nettype none
module iidr_top #(
    parameter logic [7:0] FAST_MASK = 8'h00,
    parameter logic [1:0] MODE_DEGLITCH = iidr_pkg::MODE_DEGLITCH,
    parameter logic [1:0] MODE_BLANKING = iidr_pkg::MODE_BLANKING,
    parameter logic [1:0] DLY_CODE_A = iidr_pkg::DLY_CODE_A,
    parameter logic [1:0] DLY_CODE_B = iidr_pkg::DLY_CODE_B,
    parameter logic [1:0] DLY_CODE_C = iidr_pkg::DLY_CODE_C,
    parameter logic [iidr_pkg::DLY_W-1:0] DLY_A_CYC = iidr_pkg::DLY_W'(iidr_pkg::DLY_A_CYC),
    parameter logic [iidr_pkg::DLY_W-1:0] DLY_B_CYC = iidr_pkg::DLY_W'(iidr_pkg::DLY_B_CYC),
    parameter logic [iidr_pkg::DLY_W-1:0] DLY_C_CYC = iidr_pkg::DLY_W'(iidr_pkg::DLY_C_CYC)
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // channel pins
    input wire logic [7:0] filtered_input,
    output logic [7:0] filtered_output,
    // supply comparators
    input wire logic supply_below_lower,
    input wire logic supply_above_upper,
    output logic supply_lockout,
    // serial link
    input wire logic spi_sclk,
    input wire logic spi_nss_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    output logic chain_pass_output
);
    localparam logic [iidr_pkg::LP_W-1:0] LP_MAX = iidr_pkg::LP_W'(iidr_pkg::FIXED_LP_CYC);
    localparam logic [iidr_pkg::START_W-1:0] START_LOAD = iidr_pkg::START_W'(iidr_pkg::START_CYC);

    // two-bit field of channel ch from the mode or delay registers
    function automatic logic [1:0] field_of(input iidr_pkg::iidr_cfg_type c, input logic sel_dly, input int ch);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = sel_dly ? c.dly_lo : c.kind_lo;
        hi = sel_dly ? c.dly_hi : c.kind_hi;
        field_of = (ch < 4) ? lo[2*(ch%4) +: 2] : hi[2*(ch%4) +: 2];
    endfunction

    function automatic logic [iidr_pkg::DLY_W-1:0] dly_cycles(input logic [1:0] code);
        if (code == DLY_CODE_A) dly_cycles = DLY_A_CYC;
        else if (code == DLY_CODE_B) dly_cycles = DLY_B_CYC;
        else if (code == DLY_CODE_C) dly_cycles = DLY_C_CYC;
        else dly_cycles = '0;
    endfunction

    function automatic logic [7:0] rd_mux(input logic [7:0] a, input iidr_pkg::iidr_cfg_type c, input logic [7:0] lv);
        case (a)
            iidr_pkg::ADDR_LEVEL: rd_mux = lv;
            iidr_pkg::ADDR_KIND_LO: rd_mux = c.kind_lo;
            iidr_pkg::ADDR_KIND_HI: rd_mux = c.kind_hi;
            iidr_pkg::ADDR_DLY_LO: rd_mux = c.dly_lo;
            iidr_pkg::ADDR_DLY_HI: rd_mux = c.dly_hi;
            default: rd_mux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // core domain: pin synchronisers
    logic [7:0] in_s1_ff, in_s2_ff;
    logic [1:0] sup_s1_ff, sup_s2_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_ff <= 8'h00;
            in_s2_ff <= 8'h00;
            sup_s1_ff <= 2'h0;
            sup_s2_ff <= 2'h0;
        end else begin
            in_s1_ff <= filtered_input;
            in_s2_ff <= in_s1_ff;
            sup_s1_ff <= {supply_above_upper, supply_below_lower};
            sup_s2_ff <= sup_s1_ff;
        end
    end

    // lockout with hysteresis, start-up wait, forced low, then tracking
    iidr_pkg::iidr_pwr_type pwr_st_ff;
    logic [iidr_pkg::START_W-1:0] start_cnt_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_st_ff <= iidr_pkg::ST_LOCKED;
            start_cnt_ff <= '0;
        end else if (sup_s2_ff[0]) begin
            pwr_st_ff <= iidr_pkg::ST_LOCKED;
            start_cnt_ff <= '0;
        end else begin
            case (pwr_st_ff)
                iidr_pkg::ST_LOCKED: begin
                    if (sup_s2_ff[1]) begin
                        pwr_st_ff <= iidr_pkg::ST_STARTING;
                        start_cnt_ff <= START_LOAD;
                    end
                end
                iidr_pkg::ST_STARTING: begin
                    if (start_cnt_ff == '0) pwr_st_ff <= iidr_pkg::ST_ZERO;
                    else start_cnt_ff <= start_cnt_ff - 1'b1;
                end
                iidr_pkg::ST_ZERO: pwr_st_ff <= iidr_pkg::ST_TRACK;
                iidr_pkg::ST_TRACK: pwr_st_ff <= iidr_pkg::ST_TRACK;
                default: pwr_st_ff <= iidr_pkg::ST_LOCKED;
            endcase
        end
    end

    // configuration crossing: the link holds the word still for many core cycles after a toggle
    iidr_pkg::iidr_cfg_type cfg_spi_ff, cfg_core_ff;
    logic wr_tgl_ff;
    logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
            cfg_core_ff <= '0;
        end else begin
            tgl_s1_ff <= wr_tgl_ff;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
            if (tgl_s2_ff != tgl_s3_ff) cfg_core_ff <= cfg_spi_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel filters; state runs from reset with a zero configuration
    logic [iidr_pkg::LP_W-1:0] lp_cnt_ff [iidr_pkg::NCH];
    logic [iidr_pkg::DLY_W-1:0] db_cnt_ff [iidr_pkg::NCH];
    logic [7:0] lp_out_ff, db_out_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_out_ff <= 8'h00;
            db_out_ff <= 8'h00;
            for (int i = 0; i < iidr_pkg::NCH; i++) begin
                lp_cnt_ff[i] <= '0;
                db_cnt_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < iidr_pkg::NCH; i++) begin
                // fixed low-pass: integrator that must saturate to flip
                if (in_s2_ff[i] && lp_cnt_ff[i] != LP_MAX) lp_cnt_ff[i] <= lp_cnt_ff[i] + 1'b1;
                else if (!in_s2_ff[i] && lp_cnt_ff[i] != '0) lp_cnt_ff[i] <= lp_cnt_ff[i] - 1'b1;
                if (in_s2_ff[i] && lp_cnt_ff[i] == LP_MAX - 1'b1) lp_out_ff[i] <= 1'b1;
                else if (!in_s2_ff[i] && lp_cnt_ff[i] == 8'h01) lp_out_ff[i] <= 1'b0;
                // configurable stage on top of the fixed one
                if (dly_cycles(field_of(cfg_core_ff, 1'b1, i)) == '0) begin
                    db_out_ff[i] <= lp_out_ff[i];
                    db_cnt_ff[i] <= '0;
                end else if (field_of(cfg_core_ff, 1'b0, i) == MODE_BLANKING) begin
                    // follow at once, then ignore changes for the delay
                    if (db_cnt_ff[i] != '0) db_cnt_ff[i] <= db_cnt_ff[i] - 1'b1;
                    else if (lp_out_ff[i] != db_out_ff[i]) begin
                        db_out_ff[i] <= lp_out_ff[i];
                        db_cnt_ff[i] <= dly_cycles(field_of(cfg_core_ff, 1'b1, i));
                    end
                end else if (field_of(cfg_core_ff, 1'b0, i) == MODE_DEGLITCH) begin
                    // new level must hold unbroken for the delay
                    if (lp_out_ff[i] == db_out_ff[i]) db_cnt_ff[i] <= '0;
                    else if (db_cnt_ff[i] >= dly_cycles(field_of(cfg_core_ff, 1'b1, i)) - 1'b1) begin
                        db_out_ff[i] <= lp_out_ff[i];
                        db_cnt_ff[i] <= '0;
                    end else db_cnt_ff[i] <= db_cnt_ff[i] + 1'b1;
                end else begin
                    // low-pass: up/down integrator, unknown codes land here too
                    if (lp_out_ff[i] && db_cnt_ff[i] < dly_cycles(field_of(cfg_core_ff, 1'b1, i)))
                        db_cnt_ff[i] <= db_cnt_ff[i] + 1'b1;
                    else if (!lp_out_ff[i] && db_cnt_ff[i] != '0) db_cnt_ff[i] <= db_cnt_ff[i] - 1'b1;
                    if (lp_out_ff[i] && db_cnt_ff[i] >= dly_cycles(field_of(cfg_core_ff, 1'b1, i)) - 1'b1)
                        db_out_ff[i] <= 1'b1;
                    else if (!lp_out_ff[i] && db_cnt_ff[i] <= 23'h000001) db_out_ff[i] <= 1'b0;
                end
            end
        end
    end

    // channel outputs held low except while tracking
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filtered_output <= 8'h00;
            supply_lockout <= 1'b1;
        end else begin
            supply_lockout <= (pwr_st_ff == iidr_pkg::ST_LOCKED);
            if (pwr_st_ff == iidr_pkg::ST_TRACK)
                filtered_output <= (FAST_MASK & in_s2_ff) | (~FAST_MASK & db_out_ff);
            else filtered_output <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: byte framing on rising serial clock
    logic [7:0] sh_ff, lvl_s1_ff, lvl_s2_ff, rd_sh_ff;
    logic [7:0] spi_byte, rd_word;
    logic [2:0] bit_cnt_ff;
    logic [1:0] idx_ff;
    iidr_pkg::iidr_ctl_type ctl_ff;
    logic [7:0] addr_ff;
    logic arm_ff, data_phase_ff, flip_ff, borrow_ff;
    logic write_hit, read_hit;
    assign spi_byte = {sh_ff[6:0], spi_mosi};
    assign rd_word = rd_mux(spi_byte, cfg_spi_ff, lvl_s2_ff);
    assign write_hit = !ctl_ff.rnw && (ctl_ff.bcast || ctl_ff.cid_rev == 4'h0);
    assign read_hit = ctl_ff.rnw && ctl_ff.cid_rev == 4'h0;
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
            idx_ff <= 2'h0;
        end else if (spi_nss_n) begin
            bit_cnt_ff <= 3'h0; // resync: clock with select high
            idx_ff <= 2'h0;
        end else begin
            sh_ff <= spi_byte;
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (bit_cnt_ff == 3'h7) idx_ff <= (idx_ff == 2'h2) ? 2'h0 : idx_ff + 1'b1;
        end
    end

    // control, address and register writes
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= '0;
            addr_ff <= 8'h00;
            cfg_spi_ff <= '0;
            wr_tgl_ff <= 1'b0;
        end else if (!spi_nss_n && bit_cnt_ff == 3'h7) begin
            if (idx_ff == 2'h0) ctl_ff <= spi_byte;
            if (idx_ff == 2'h1) addr_ff <= spi_byte;
            // only a full eighth edge commits; aborted writes leave the register alone
            if (idx_ff == 2'h2 && write_hit) begin
                case (addr_ff)
                    iidr_pkg::ADDR_KIND_LO: cfg_spi_ff.kind_lo <= spi_byte;
                    iidr_pkg::ADDR_KIND_HI: cfg_spi_ff.kind_hi <= spi_byte;
                    iidr_pkg::ADDR_DLY_LO: cfg_spi_ff.dly_lo <= spi_byte;
                    iidr_pkg::ADDR_DLY_HI: cfg_spi_ff.dly_hi <= spi_byte;
                    default: cfg_spi_ff <= cfg_spi_ff;
                endcase
                wr_tgl_ff <= !wr_tgl_ff;
            end
        end
    end

    // read path; live levels re-synchronised into the link clock
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_s1_ff <= 8'h00;
            lvl_s2_ff <= 8'h00;
            rd_sh_ff <= 8'h00;
            spi_miso <= 1'b0;
            arm_ff <= 1'b0;
        end else begin
            lvl_s1_ff <= in_s2_ff;
            lvl_s2_ff <= lvl_s1_ff;
            if (spi_nss_n) arm_ff <= 1'b0;
            else if (bit_cnt_ff == 3'h7 && idx_ff == 2'h1 && read_hit) begin
                arm_ff <= 1'b1;
                spi_miso <= rd_word[7];
                rd_sh_ff <= {rd_word[6:0], 1'b0};
            end else if (bit_cnt_ff == 3'h7 && idx_ff == 2'h2) arm_ff <= 1'b0;
            else if (idx_ff == 2'h2 && arm_ff) begin
                spi_miso <= rd_sh_ff[7];
                rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
            end
        end
    end

    // the data byte starts only after select has risen once behind the address byte
    always_ff @(posedge spi_nss_n or negedge rst_n) begin
        if (!rst_n) data_phase_ff <= 1'b0;
        else data_phase_ff <= arm_ff;
    end
    // enable low only while selected in the data byte; gated by select so it drops with the frame
    assign spi_miso_oe_n = !(arm_ff && data_phase_ff && !spi_nss_n);

    // pass-through: serial decrement of the id, which arrives lsb first
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            flip_ff <= 1'b0;
            borrow_ff <= 1'b1;
        end else if (spi_nss_n) begin
            flip_ff <= 1'b0;
            borrow_ff <= 1'b1;
        end else if (idx_ff == 2'h0) begin
            if (bit_cnt_ff >= 3'h4) borrow_ff <= borrow_ff && !spi_mosi;
            else borrow_ff <= 1'b1;
            if (bit_cnt_ff >= 3'h3 && bit_cnt_ff != 3'h7)
                flip_ff <= (bit_cnt_ff == 3'h3) ? 1'b1 : (borrow_ff && !spi_mosi);
            else flip_ff <= 1'b0;
        end else flip_ff <= 1'b0;
    end
    // combinational so the next device sees the bit in the same clock period
    assign chain_pass_output = spi_mosi ^ flip_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_byte_end;
        !spi_nss_n && bit_cnt_ff == 3'h7;
    endsequence
    sequence s_addr_read(logic [7:0] a);
        s_byte_end ##0 idx_ff == 2'h1 && read_hit && spi_byte == a;
    endsequence

    a_lockout_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwr_st_ff != iidr_pkg::ST_TRACK |=> filtered_output == 8'h00) else $error("outputs not low outside tracking");
    a_lockout_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        sup_s2_ff[0] |=> pwr_st_ff == iidr_pkg::ST_LOCKED ##1 supply_lockout) else $error("lockout not entered");
    a_start_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(pwr_st_ff == iidr_pkg::ST_STARTING) ##0 !sup_s2_ff[0] [*8] |-> pwr_st_ff == iidr_pkg::ST_STARTING)
        else $error("start-up interval cut short");
    a_zero_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(pwr_st_ff == iidr_pkg::ST_TRACK) |-> $past(pwr_st_ff) == iidr_pkg::ST_ZERO && filtered_output == 8'h00)
        else $error("tracking without forced low");
    a_fixed_lowpass: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(lp_out_ff[0]) |-> $past(lp_cnt_ff[0]) == LP_MAX - 1'b1) else $error("fixed low-pass too short");
    a_byte_advance: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        s_byte_end |=> idx_ff == (($past(idx_ff) == 2'h2) ? 2'h0 : $past(idx_ff) + 2'h1)) else $error("byte counter wrong");
    a_status_read: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        s_addr_read(iidr_pkg::ADDR_LEVEL) |=> spi_miso == $past(lvl_s2_ff[7]) && rd_sh_ff == {$past(lvl_s2_ff[6:0]), 1'b0})
        else $error("status read mismatch");
    a_unmapped_zero: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        s_byte_end ##0 idx_ff == 2'h1 && read_hit && spi_byte > iidr_pkg::ADDR_DLY_HI |=> !spi_miso && rd_sh_ff == 8'h00)
        else $error("unmapped read not zero");
    a_miso_quiet: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        idx_ff != 2'h2 |-> spi_miso_oe_n) else $error("data output driven outside data byte");
    a_mode_write: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        s_byte_end ##0 idx_ff == 2'h2 && write_hit && addr_ff == iidr_pkg::ADDR_KIND_LO
        |=> cfg_spi_ff.kind_lo == $past(spi_byte) && wr_tgl_ff != $past(wr_tgl_ff)) else $error("mode write lost");
    a_cid_forward: assert property (@(posedge spi_sclk) disable iff (!rst_n)
        !spi_nss_n && idx_ff == 2'h0 && bit_cnt_ff == 3'h3 |=> flip_ff) else $error("id decrement missing");
endmodule // iidr_top
`default_nettype wire

// file: bench/iidr_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module iidr_spi_host (
    // link pins
    output logic sclk,
    output logic nss_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic pass_out
);
    logic [7:0] rx;
    logic [7:0] pass_rx;
    logic [7:0] pass_ctl;
    int drv_cnt;
    // link clock rests low outside frames
    initial begin
        sclk = 1'b0;
        nss_n = 1'b1;
        mosi = 1'b0;
        rx = 8'h00;
        pass_rx = 8'h00;
        pass_ctl = 8'h00;
        drv_cnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one byte under select, msb first, 48 ns period
    task automatic xfer_byte(input logic [7:0] tx);
        nss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #24;
            // a released line reads as the inverse of the last bit
            rx = {rx[6:0], (miso_oe_n === 1'b0) ? miso : ~rx[0]};
            pass_rx = {pass_rx[6:0], pass_out};
            if (miso_oe_n === 1'b0) drv_cnt++;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        #24;
        nss_n = 1'b1;
        mosi = ~mosi;
        #48;
    endtask
    // control, address and data byte
    task automatic packet(input logic [7:0] ctl, input logic [7:0] addr, input logic [7:0] data);
        drv_cnt = 0;
        xfer_byte(ctl);
        pass_ctl = pass_rx;
        xfer_byte(addr);
        xfer_byte(data);
    endtask
endmodule // iidr_spi_host
`default_nettype wire

// file: bench/iidr_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module iidr_top_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] fin = 8'h00;
    logic below = 1'b0;
    logic above = 1'b0;
    logic [7:0] fout;
    logic lockout, sclk, nss_n, mosi, miso, miso_oe_n, pass_out;
    logic [7:0] vals [4] = '{8'hE4, 8'h1B, 8'h39, 8'hC6};
    int err_total = 0;
    int check_count = 0;
    // 50 MHz core clock
    always #10 core_clk = ~core_clk;
    // short debounce counts keep the run brief; channel 7 is a fast one
    iidr_top #(.FAST_MASK(8'h80), .DLY_A_CYC(23'h000032), .DLY_B_CYC(23'h000096), .DLY_C_CYC(23'h0001F4)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .filtered_input(fin), .filtered_output(fout),
        .supply_below_lower(below), .supply_above_upper(above), .supply_lockout(lockout),
        .spi_sclk(sclk), .spi_nss_n(nss_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe_n(miso_oe_n), .chain_pass_output(pass_out));
    iidr_spi_host i_host (.sclk(sclk), .nss_n(nss_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .pass_out(pass_out));
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setin(input logic [7:0] f, input logic b, input logic a);
        @(posedge core_clk);
        fin <= f;
        below <= b;
        above <= a;
    endtask
    task automatic rd(input logic [7:0] ctl, input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] drv);
        i_host.packet(ctl, addr, 8'h00);
        if (drv == 8'h08) chk(i_host.rx, exp);
        chk(8'(i_host.drv_cnt), drv);
    endtask
    task automatic wr(input logic [7:0] ctl, input logic [7:0] addr, input logic [7:0] d);
        i_host.packet(ctl, addr, d);
        chk(8'(i_host.drv_cnt), 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_power;
        chk({7'h00, lockout}, 8'h01);
        setin(8'hFF, 1'b0, 1'b1);
        cyc(1000);
        chk(fout, 8'h00);
        setin(8'h00, 1'b0, 1'b1);
        cyc(1400);
        setin(8'hFF, 1'b0, 1'b1);
        cyc(20);
        chk(fout, 8'h80);
        cyc(230);
        chk(fout, 8'hFF);
        setin(8'h00, 1'b0, 1'b1);
        cyc(150);
        chk(fout, 8'h7F);
        cyc(100);
        chk(fout, 8'h00);
        $display("t_power done");
    endtask
    task automatic t_regs;
        for (int a = 1; a <= 4; a++) rd(8'h40, 8'(a), 8'h00, 8'h08);
        setin(8'hA5, 1'b0, 1'b1);
        cyc(5);
        wr(8'h00, 8'h00, 8'h3C);
        rd(8'h40, 8'h00, 8'hA5, 8'h08);
        // the second register goes by broadcast to a nonzero id
        for (int a = 1; a <= 4; a++) wr((a == 2) ? 8'h88 : 8'h00, 8'(a), vals[a-1]);
        for (int a = 1; a <= 4; a++) rd(8'h40, 8'(a), vals[a-1], 8'h08);
        rd(8'h40, 8'h05, 8'h00, 8'h08);
        rd(8'hC0, 8'hFF, 8'h00, 8'h08);
        rd(8'h48, 8'h01, 8'h00, 8'h00);
        chk(i_host.pass_ctl, 8'h40);
        wr(8'h08, 8'h01, 8'h00);
        rd(8'h40, 8'h01, 8'hE4, 8'h08);
        $display("t_regs done");
    endtask
    task automatic t_delay;
        // start from all channels low, so the rise below is a real edge
        setin(8'h00, 1'b0, 1'b1);
        cyc(300);
        chk(fout, 8'h00);
        // channel 0 deglitch, channel 1 blanking, both on the shortest delay
        wr(8'h00, 8'h01, 8'h08);
        wr(8'h00, 8'h03, 8'h05);
        setin(8'h03, 1'b0, 1'b1);
        cyc(230);
        chk(fout & 8'h03, 8'h02);
        cyc(60);
        chk(fout & 8'h03, 8'h03);
        $display("t_delay done");
    endtask
    task automatic t_lockout;
        setin(8'hFF, 1'b1, 1'b0);
        cyc(6);
        chk({7'h00, lockout}, 8'h01);
        chk(fout, 8'h00);
        setin(8'hFF, 1'b0, 1'b0);
        cyc(300);
        chk({7'h00, lockout}, 8'h01);
        chk(fout, 8'h00);
        $display("t_lockout done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main flow or the watchdog
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main flow
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(4);
        t_power;
        t_regs;
        t_delay;
        t_lockout;
        test_done;
    end
    // watchdog, several times the expected run
    initial begin
        #400000;
        err_total++;
        test_done;
    end
endmodule // iidr_top_tb
`default_nettype wire
